/* verilog/pmdis_map.svh */
// Purpose: Offsets, field positions, masks and reset values of the disable bank.
// Assumes: Wishbone byte addresses, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef PMDIS_MAP_SVH
`define PMDIS_MAP_SVH
`define PMDIS_OFF_CTRL0    8'h00
`define PMDIS_OFF_CTRL1    8'h04
`define PMDIS_OFF_CTRL2    8'h08
`define PMDIS_OFF_CTRL3    8'h0C
`define PMDIS_OFF_CTRL4    8'h10
`define PMDIS_MASK_CTRL0   8'hC7
`define PMDIS_MASK_CTRL1   8'hFF
`define PMDIS_MASK_CTRL2   8'h66
`define PMDIS_MASK_CTRL3   8'hFF
`define PMDIS_MASK_CTRL4   8'h26
`define PMDIS_RESET_VALUE  8'h00
`define PMDIS_BIT_SYSTEM_CLOCK_NET   7
`define PMDIS_BIT_VREF     6
`define PMDIS_BIT_EEPROM   2
`define PMDIS_BIT_CLKOUT   1
`define PMDIS_BIT_PINCHG   0
`define PMDIS_NV_WAIT_NS   1000
`define PMDIS_CLK_NS       4
`endif

/* verilog/pmdis_pkg.sv */
// Purpose: Types shared by the disable bank.
// Assumes: Nothing beyond the map header.
// Notes:   Register select encoding.
`default_nettype none
package pmdis_pkg;
   typedef enum logic [2:0] {
      PMDIS_SEL_R0, PMDIS_SEL_R1, PMDIS_SEL_R2, PMDIS_SEL_R3, PMDIS_SEL_R4, PMDIS_SEL_NONE
   } pmdis_sel_t;
endpackage : pmdis_pkg
`default_nettype wire

/* verilog/pmdis_top.sv */
// Purpose: Peripheral disable register bank with clock and reset gating outputs.
// Assumes: Classic Wishbone slave, 32-bit data, one clock, synchronous reset.
// Notes:   Ack comes one cycle after request; outputs all registered.
`include "pmdis_map.svh"
`timescale 1ns/1ps
`default_nettype none
module pmdis_top
   import pmdis_pkg::*;
#(
   parameter int NUM_REGS = 5
) (
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave.
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Per-peripheral gating, one bit per control bit position.
   output logic      [39:0] periph_clk_en_o,
   output logic      [39:0] periph_rst_o,
   output logic      [39:0] periph_off_o,
   // Memory and system clock controls.
   output logic             system_clock_net_net_off_o,
   output logic             eeprom_off_o,
   output logic             nv_ctrl_wr_block_o,
   output logic             indirect_eeprom_zero_o
);

   // Implemented-bit mask of a register index.
   function automatic logic [7:0] reg_mask(input int idx);
      case (idx)
         0: reg_mask = `PMDIS_MASK_CTRL0;
         1: reg_mask = `PMDIS_MASK_CTRL1;
         2: reg_mask = `PMDIS_MASK_CTRL2;
         3: reg_mask = `PMDIS_MASK_CTRL3;
         4: reg_mask = `PMDIS_MASK_CTRL4;
         default: reg_mask = 8'h00;
      endcase
   endfunction : reg_mask

   logic [7:0]  ctrl_r [NUM_REGS];
   logic [39:0] flat_w;
   pmdis_sel_t  sel_w;
   logic        req_w;
   logic        wr_w;
   logic [7:0]  rd_w;

   // Address decode and request qualification.
   assign req_w = cyc_i & stb_i & ~ack_o;
   assign wr_w  = req_w & we_i & sel_i[0];
   assign sel_w = (adr_i == `PMDIS_OFF_CTRL0) ? PMDIS_SEL_R0 :
                  (adr_i == `PMDIS_OFF_CTRL1) ? PMDIS_SEL_R1 :
                  (adr_i == `PMDIS_OFF_CTRL2) ? PMDIS_SEL_R2 :
                  (adr_i == `PMDIS_OFF_CTRL3) ? PMDIS_SEL_R3 :
                  (adr_i == `PMDIS_OFF_CTRL4) ? PMDIS_SEL_R4 : PMDIS_SEL_NONE;
   assign rd_w  = (sel_w == PMDIS_SEL_NONE) ? 8'h00 : ctrl_r[int'(sel_w)];

   // Control registers; writes masked so unimplemented bits stay zero.
   for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            ctrl_r[g] <= `PMDIS_RESET_VALUE;
         end else if (wr_w && int'(sel_w) == g) begin
            ctrl_r[g] <= dat_i[7:0] & reg_mask(g);
         end
      end
      assign flat_w[g*8 +: 8] = ctrl_r[g];
   end

   // Bus answer: one-cycle ack, unmapped reads give zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= req_w;
         dat_o <= req_w ? {24'h00_0000, rd_w} : 32'h0000_0000;
      end
   end

   // Gating outputs registered from the control bits; left to peripheral wiring.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         periph_clk_en_o        <= {40{1'b1}};
         periph_rst_o           <= 40'h00_0000_0000;
         periph_off_o           <= 40'h00_0000_0000;
         system_clock_net_net_off_o       <= 1'b0;
         eeprom_off_o           <= 1'b0;
         nv_ctrl_wr_block_o     <= 1'b0;
         indirect_eeprom_zero_o <= 1'b0;
      end else begin
         periph_clk_en_o        <= ~flat_w;
         periph_rst_o           <= flat_w;
         periph_off_o           <= flat_w;
         system_clock_net_net_off_o       <= ctrl_r[0][`PMDIS_BIT_SYSTEM_CLOCK_NET];
         eeprom_off_o           <= ctrl_r[0][`PMDIS_BIT_EEPROM];
         nv_ctrl_wr_block_o     <= ctrl_r[0][`PMDIS_BIT_EEPROM];
         indirect_eeprom_zero_o <= ctrl_r[0][`PMDIS_BIT_EEPROM];
      end
   end

   // Helper: previous register-0 write and its data for assertions.
   logic wr0_q;
   logic [7:0] wdat_q;
   always_ff @(posedge clk_i) begin
      wr0_q  <= wr_w && sel_w == PMDIS_SEL_R0;
      wdat_q <= dat_i[7:0];
   end

   property p_ack_next;
      @(posedge clk_i) disable iff (rst_i) req_w |=> ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack missing");
   property p_ack_drop;
      @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
   endproperty
   a_ack_drop: assert property (p_ack_drop) else $error("ack held");
   property p_unimpl0;
      @(posedge clk_i) disable iff (rst_i) (ctrl_r[0] & ~`PMDIS_MASK_CTRL0) == 8'h00;
   endproperty
   a_unimpl0: assert property (p_unimpl0) else $error("reg0 reserved set");
   property p_unimpl2;
      @(posedge clk_i) disable iff (rst_i) (ctrl_r[2] & ~`PMDIS_MASK_CTRL2) == 8'h00;
   endproperty
   a_unimpl2: assert property (p_unimpl2) else $error("reg2 reserved set");
   property p_unimpl4;
      @(posedge clk_i) disable iff (rst_i) (ctrl_r[4] & ~`PMDIS_MASK_CTRL4) == 8'h00;
   endproperty
   a_unimpl4: assert property (p_unimpl4) else $error("reg4 reserved set");
   property p_reset_clear;
      @(posedge clk_i) rst_i |=> (ctrl_r[1] == 8'h00 && !ack_o);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset value");
   property p_system_clock_net;
      @(posedge clk_i) disable iff (rst_i)
         wr0_q |=> system_clock_net_net_off_o == $past(wdat_q[`PMDIS_BIT_SYSTEM_CLOCK_NET]);
   endproperty
   a_system_clock_net: assert property (p_system_clock_net) else $error("system_clock_net gate");
   property p_eeprom;
      @(posedge clk_i) disable iff (rst_i)
         wr0_q |=> (eeprom_off_o == $past(wdat_q[`PMDIS_BIT_EEPROM])) &&
                   (nv_ctrl_wr_block_o == eeprom_off_o) &&
                   (indirect_eeprom_zero_o == eeprom_off_o);
   endproperty
   a_eeprom: assert property (p_eeprom) else $error("eeprom gate");
   property p_gate;
      @(posedge clk_i) disable iff (rst_i) ##1 periph_clk_en_o == ~$past(flat_w);
   endproperty
   a_gate: assert property (p_gate) else $error("clock gate");
   property p_rst_pair;
      @(posedge clk_i) disable iff (rst_i) periph_rst_o == ~periph_clk_en_o;
   endproperty
   a_rst_pair: assert property (p_rst_pair) else $error("reset gate");

   // A taken write to register 0 stores the data with reserved bits cleared.
   property p_write_lands;
      @(posedge clk_i) disable iff (rst_i)
         (wr_w && sel_w == PMDIS_SEL_R0) |=>
            ctrl_r[0] == ($past(dat_i[7:0]) & `PMDIS_MASK_CTRL0);
   endproperty
   a_write_lands: assert property (p_write_lands) else $error("write lost");

   // A read of an unmapped offset answers with zero data.
   property p_read_unmapped;
      @(posedge clk_i) disable iff (rst_i)
         (req_w && !we_i && sel_w == PMDIS_SEL_NONE) |=> dat_o == 32'h0000_0000;
   endproperty
   a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read");

   // The register-access block line always matches the hold-in-reset line.
   property p_off_pair;
      @(posedge clk_i) disable iff (rst_i) periph_off_o == periph_rst_o;
   endproperty
   a_off_pair: assert property (p_off_pair) else $error("off gate");
   c_write: cover property (@(posedge clk_i) wr_w ##1 ack_o);
   c_read: cover property (@(posedge clk_i) req_w && !we_i ##1 ack_o);
   c_sysoff: cover property (@(posedge clk_i) system_clock_net_net_off_o);
   c_eeoff: cover property (@(posedge clk_i) eeprom_off_o);

endmodule : pmdis_top
`default_nettype wire

/* bench/pmdis_periph_model.sv */
// Purpose: Behavioural peripheral fed by one clock-enable and one hold-in-reset line.
// Assumes: Both gating lines come straight from the disable bank.
// Notes:   A counter that advances only while clock-enabled and not held shows whether the peripheral is live.
`timescale 1ns/1ps
`default_nettype none
module pmdis_periph_model (
   // Clock and system reset.
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Gating from the disable bank.
   input  wire logic       clk_en_i,
   input  wire logic       hold_i,
   // Activity seen by the bench.
   output logic      [3:0] cnt_o
);
   // Held at power-on state while gated off, counts only while clocked.
   always_ff @(posedge clk_i) begin
      if (rst_i || hold_i) cnt_o <= 4'h0;
      else if (clk_en_i) cnt_o <= cnt_o + 4'h1;
   end
endmodule : pmdis_periph_model
`default_nettype wire

/* bench/pmdis_tb_top.sv */
// Purpose: Self-checking bench of the disable bank over classic Wishbone.
// Assumes: Ack arrives one cycle after a request; gating follows one edge later.
// Notes:   Random values come from an LFSR with a fixed start.
`include "pmdis_map.svh"
`timescale 1ns/1ps
`default_nettype none
module pmdis_tb_top;
   import pmdis_pkg::*;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd, seed = 32'hF6646BAF;
   logic        ack_o, system_clock_net_net_off_o, eeprom_off_o, nv_ctrl_wr_block_o, indirect_eeprom_zero_o;
   logic [39:0] periph_clk_en_o, periph_rst_o, periph_off_o;
   logic [3:0]  cnt;
   logic [7:0]  img [6];
   int          errors = 0, num_checks = 0, i;
   pmdis_top uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
      .ack_o, .periph_clk_en_o, .periph_rst_o, .periph_off_o, .system_clock_net_net_off_o,
      .eeprom_off_o, .nv_ctrl_wr_block_o, .indirect_eeprom_zero_o);
   pmdis_periph_model u_tmr0 (.clk_i, .rst_i, .clk_en_i(periph_clk_en_o[8]),
      .hold_i(periph_rst_o[8]), .cnt_o(cnt));
   // Free-running 250 MHz clock.
   always #2 clk_i = ~clk_i;
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic logic [7:0] msk(input int r);
      case (r)
         0: return `PMDIS_MASK_CTRL0;
         1: return `PMDIS_MASK_CTRL1;
         2: return `PMDIS_MASK_CTRL2;
         3: return `PMDIS_MASK_CTRL3;
         default: return `PMDIS_MASK_CTRL4;
      endcase
   endfunction : msk
   task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
      num_checks++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic s);
      @(posedge clk_i);
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= {24'h0, d};
      sel_i <= {3'h0, s};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0; stb_i <= 1'b0;
   endtask : wb
   task automatic wr(input int r, input logic [7:0] d, input logic s);
      wb(1'b1, 8'(r * 4), d, s);
      if (s && r < 5) img[r] = d & msk(r);
      @(posedge clk_i);
      #1;
   endtask : wr
   task automatic rdchk(input int r);
      wb(1'b0, 8'(r * 4), 8'h00, 1'b1);
      chk("read", {8'h0, rd}, {32'h0, img[r]});
   endtask : rdchk
   task automatic check_out;
      logic [39:0] v;
      v = {img[4], img[3], img[2], img[1], img[0]};
      chk("gate", periph_rst_o, v);
      chk("off", periph_off_o, v);
      chk("clk_en", periph_clk_en_o, ~v);
      chk("system_clock_net", {39'h0, system_clock_net_net_off_o}, {39'h0, img[0][7]});
      chk("eeprom", {37'h0, eeprom_off_o, nv_ctrl_wr_block_o, indirect_eeprom_zero_o},
         {37'h0, {3{img[0][2]}}});
   endtask : check_out
   // Hang guard.
   initial begin
      repeat (5000) @(posedge clk_i);
      errors++;
      test_done();
   end
   // Reset, all-ones corners, random traffic, refusals, gating and a second reset.
   initial begin
      img = '{default: 8'h00};
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 5; i++) rdchk(i);
      check_out();
      for (int k = 0; k < 30; k++) begin
         seed = lfsr(seed);
         i = (k < 5) ? k : int'(seed[2:0]) % 5;
         wr(i, (k < 5) ? 8'hFF : seed[15:8], 1'b1);
         rdchk(i);
         check_out();
      end
      wr(5, 8'hFF, 1'b1);
      wr(1, ~img[1], 1'b0);
      for (i = 1; i < 6; i += 4) rdchk(i);
      check_out();
      wr(1, 8'h00, 1'b1);
      repeat (3) @(posedge clk_i);
      chk("live", {39'h0, cnt != 4'h0}, 40'h1);
      wr(1, 8'h01, 1'b1);
      repeat (2) @(posedge clk_i);
      chk("held", {36'h0, cnt}, 40'h0);
      wr(1, 8'h00, 1'b1);
      @(posedge clk_i); // Idle one cycle after re-enable.
      repeat (3) @(posedge clk_i);
      chk("restart", {39'h0, cnt != 4'h0}, 40'h1);
      wr(0, 8'hFF, 1'b1);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      img = '{default: 8'h00};
      @(posedge clk_i);
      #1;
      check_out();
      repeat (`PMDIS_NV_WAIT_NS / `PMDIS_CLK_NS) @(posedge clk_i);
      for (i = 0; i < 5; i++) rdchk(i);
      test_done();
   end
endmodule : pmdis_tb_top
`default_nettype wire
